// file: acs_pkg.sv
// constants and types for the calibration sequencer
package acs_pkg;
    localparam int RAW_W   = 24;
    localparam int CAL_W   = 33;
    localparam int OUT_W   = 24;
    localparam int GAIN_W  = 3;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF   = 3'h1;
    localparam logic [2:0] MODE_SYS0   = 3'h2;
    localparam logic [2:0] MODE_SYS1   = 3'h3;
    localparam logic [2:0] MODE_SOFF   = 3'h4;
    localparam logic [2:0] MODE_BACK   = 3'h5;
    localparam logic [3:0] PER_SELF    = 4'h9;
    localparam logic [3:0] PER_SYS     = 4'h4;
    localparam logic [3:0] PER_BACK    = 4'h6;
    localparam logic [3:0] SEL_AIN     = 4'h0;
    localparam logic [1:0] SRC_AIN     = 2'h0;
    localparam logic [1:0] SRC_SHORT   = 2'h1;
    localparam logic [1:0] SRC_REF     = 2'h2;
    localparam logic [CAL_W-1:0] GAIN_UNITY = 33'h0_4000_0000;
    localparam logic [RAW_W-1:0] MID_CODE   = 24'h80_0000;
    localparam logic [RAW_W-1:0] FULL_CODE  = 24'hff_ffff;
    localparam int GAIN_FRAC = 30;
    typedef enum logic [2:0] {
        ACS_IDLE, ACS_ZERO, ACS_FULL, ACS_SETTLE, ACS_DONE
    } acs_state_t;
endpackage

// file: acs_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// file: acs_corr.sv
// offset subtract then gain multiply, one cycle
`timescale 1ns/1ps
module acs_corr (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       in_vld,
    input  wire logic [acs_pkg::RAW_W-1:0]  raw,
    input  wire logic [acs_pkg::CAL_W-1:0]  offset,
    input  wire logic [acs_pkg::CAL_W-1:0]  gain,
    output logic                            out_vld,
    output logic      [acs_pkg::OUT_W-1:0]  result
);
    // 34-bit difference keeps sign of below-offset codes
    wire logic signed [acs_pkg::CAL_W:0]   diff;
    wire logic signed [2*acs_pkg::CAL_W+1:0] prod;
    wire logic signed [2*acs_pkg::CAL_W+1:0] scaled;
    wire logic [acs_pkg::OUT_W-1:0]       clipped;
    assign diff   = $signed({2'h0, raw}) - $signed({1'b0, offset});
    assign prod   = diff * $signed({2'h0, gain[acs_pkg::CAL_W-2:0]});
    assign scaled = prod >>> acs_pkg::GAIN_FRAC;
    // clamp keeps overrange from wrapping
    assign clipped = scaled < 0 ? '0 :
                     (scaled > $signed({44'h0, acs_pkg::FULL_CODE})) ? acs_pkg::FULL_CODE :
                     scaled[acs_pkg::OUT_W-1:0];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_vld <= 1'b0;
            result  <= '0;
        end else begin
            out_vld <= in_vld;
            if (in_vld) begin
                result <= clipped;
            end
        end
    end
endmodule

// file: acs_seq.sv
// calibration sequencer top: mode decode, point capture, coefficients
`timescale 1ns/1ps
module acs_seq (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      cal_mode_bit2,
    input  wire logic                      cal_mode_bit1,
    input  wire logic                      cal_mode_bit0,
    input  wire logic                      mode_wr,
    input  wire logic                      bipolar,
    input  wire logic [acs_pkg::GAIN_W-1:0] pga_gain,
    input  wire logic                      word_16,
    input  wire logic                      out_period,
    input  wire logic                      filt_vld,
    input  wire logic [acs_pkg::RAW_W-1:0] filt_data,
    input  wire logic                      last_bit_read,
    output logic                           filter_reset,
    output logic      [1:0]                input_select,
    output logic      [acs_pkg::OUT_W-1:0] out_word,
    output logic                           out_invalid,
    output logic                           data_ready_n
);
    logic [2:0]                 mode_r;
    acs_pkg::acs_state_t        state_r;
    logic [3:0]                 per_cnt_r;
    logic [2:0]                 bg_cnt_r;
    logic                       bg_first_r;
    logic                       sys_full_r;
    logic [acs_pkg::CAL_W-1:0]  offset_r;
    logic [acs_pkg::CAL_W-1:0]  gain_r;
    logic [acs_pkg::RAW_W-1:0]  zero_pt_r;
    logic [acs_pkg::GAIN_W-1:0] cal_gain_r;
    logic                       last_bit_s;
    logic [1:0]                 input_select_nxt;
    wire logic [2:0] mode_in = {cal_mode_bit2, cal_mode_bit1, cal_mode_bit0};
    wire logic       is_cal  = mode_in inside {acs_pkg::MODE_SELF, acs_pkg::MODE_SYS0,
                                               acs_pkg::MODE_SYS1, acs_pkg::MODE_SOFF,
                                               acs_pkg::MODE_BACK};
    wire logic       cmd_go  = mode_wr && is_cal;
    wire logic       bg_on   = mode_r == acs_pkg::MODE_BACK;
    // read strobe comes from the serial pin domain
    acs_sync #(.W(1)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (last_bit_read),
        .q       (last_bit_s)
    );
    logic rd_prev_r;
    wire logic rd_edge = last_bit_s && !rd_prev_r;
    // total output periods for each calibration kind other than background
    wire logic [3:0] dur = (mode_r == acs_pkg::MODE_SYS0 || mode_r == acs_pkg::MODE_SYS1)
                           ? acs_pkg::PER_SYS : acs_pkg::PER_SELF;
    // bipolar zero point sits at midscale
    wire logic [acs_pkg::RAW_W-1:0] zero_ref = bipolar ? acs_pkg::MID_CODE : '0;
    wire logic [acs_pkg::RAW_W-1:0] span_ref = acs_pkg::FULL_CODE - zero_ref;
    wire logic [acs_pkg::RAW_W-1:0] meas_span = filt_data - zero_pt_r;
    // gain = ideal span / measured span, Q3.30
    wire logic [acs_pkg::CAL_W+acs_pkg::GAIN_FRAC-1:0] num =
        {{(acs_pkg::CAL_W-acs_pkg::RAW_W){1'b0}}, span_ref} << acs_pkg::GAIN_FRAC;
    wire logic [acs_pkg::CAL_W+acs_pkg::GAIN_FRAC-1:0] quo =
        (meas_span == '0) ? {{acs_pkg::GAIN_FRAC{1'b0}}, acs_pkg::GAIN_UNITY}
                          : num / {{(acs_pkg::CAL_W+acs_pkg::GAIN_FRAC-acs_pkg::RAW_W){1'b0}},
                                   meas_span};
    wire logic [acs_pkg::CAL_W-1:0] new_gain = quo[acs_pkg::CAL_W-1:0];
    wire logic [acs_pkg::CAL_W-1:0] new_off  =
        {{(acs_pkg::CAL_W-acs_pkg::RAW_W){1'b0}}, filt_data};
    // phase bookkeeping in output periods
    wire logic half = per_cnt_r == 4'h1;
    wire logic zero_cap = filt_vld && state_r == acs_pkg::ACS_ZERO;
    wire logic full_cap = filt_vld && state_r == acs_pkg::ACS_FULL;
    wire logic bg_zero  = bg_on && filt_vld && bg_cnt_r == 3'h4;
    wire logic bg_full  = bg_on && filt_vld && bg_cnt_r == 3'h5;
    wire logic bg_word  = bg_on && filt_vld && bg_cnt_r == 3'h0;
    wire logic norm_word = !bg_on && state_r == acs_pkg::ACS_IDLE && filt_vld;
    wire logic corr_vld;
    wire logic [acs_pkg::OUT_W-1:0] corr_word;
    acs_corr u_corr (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .in_vld  (norm_word || bg_word),
        .raw     (filt_data),
        .offset  (offset_r),
        .gain    (gain_r),
        .out_vld (corr_vld),
        .result  (corr_word)
    );
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r    <= acs_pkg::MODE_NORMAL;
            state_r   <= acs_pkg::ACS_IDLE;
            per_cnt_r <= '0;
            filter_reset <= 1'b0;
        end else begin
            filter_reset <= cmd_go;
            if (mode_wr) begin
                mode_r <= mode_in;
            end
            if (cmd_go && mode_in != acs_pkg::MODE_BACK) begin
                state_r   <= (mode_in == acs_pkg::MODE_SYS1) ? acs_pkg::ACS_FULL
                                                              : acs_pkg::ACS_ZERO;
                per_cnt_r <= '0;
            end else if (cmd_go) begin
                state_r <= acs_pkg::ACS_IDLE;
            end else begin
                if (out_period && state_r != acs_pkg::ACS_IDLE) begin
                    per_cnt_r <= per_cnt_r + 4'h1;
                end
                unique case (state_r)
                    acs_pkg::ACS_IDLE:   state_r <= acs_pkg::ACS_IDLE;
                    acs_pkg::ACS_ZERO: begin
                        if (zero_cap) begin
                            state_r <= (mode_r == acs_pkg::MODE_SYS0) ? acs_pkg::ACS_SETTLE
                                                                      : acs_pkg::ACS_FULL;
                        end
                    end
                    acs_pkg::ACS_FULL: begin
                        if (full_cap) begin
                            state_r <= acs_pkg::ACS_SETTLE;
                        end
                    end
                    acs_pkg::ACS_SETTLE: begin
                        if (out_period && per_cnt_r >= dur - 4'h1) begin
                            state_r <= acs_pkg::ACS_DONE;
                        end
                    end
                    acs_pkg::ACS_DONE:   state_r <= acs_pkg::ACS_IDLE;
                endcase
            end
        end
    end
    // calibration source mux for the modulator front end
    always_comb begin
        input_select_nxt = acs_pkg::SRC_AIN;
        if (state_r == acs_pkg::ACS_ZERO && (mode_r == acs_pkg::MODE_SELF)) begin
            input_select_nxt = acs_pkg::SRC_SHORT;
        end else if (state_r == acs_pkg::ACS_FULL &&
                     (mode_r == acs_pkg::MODE_SELF || mode_r == acs_pkg::MODE_SOFF)) begin
            input_select_nxt = acs_pkg::SRC_REF;
        end else if (bg_on && bg_cnt_r == 3'h4) begin
            input_select_nxt = acs_pkg::SRC_SHORT;
        end else if (bg_on && bg_cnt_r == 3'h5) begin
            input_select_nxt = acs_pkg::SRC_REF;
        end
    end
    // registered select lags state by one cycle, far ahead of the next word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            input_select <= acs_pkg::SRC_AIN;
        end else begin
            input_select <= input_select_nxt;
        end
    end
    // coefficient capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            offset_r   <= '0;
            gain_r     <= acs_pkg::GAIN_UNITY;
            zero_pt_r  <= '0;
            cal_gain_r <= '0;
            sys_full_r <= 1'b0;
        end else begin
            if (zero_cap || bg_zero) begin
                zero_pt_r  <= filt_data;
                offset_r   <= new_off - {{(acs_pkg::CAL_W-acs_pkg::RAW_W){1'b0}}, zero_ref};
                cal_gain_r <= pga_gain;
            end
            if (full_cap || bg_full) begin
                gain_r <= new_gain;
            end
            if (full_cap && mode_r == acs_pkg::MODE_SYS1) begin
                sys_full_r <= 1'b1;
            end
        end
    end
    // background slot counter, six slots per delivered word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bg_cnt_r   <= '0;
            bg_first_r <= 1'b0;
            rd_prev_r  <= 1'b0;
        end else begin
            rd_prev_r <= last_bit_s;
            if (cmd_go) begin
                bg_cnt_r   <= '0;
                bg_first_r <= mode_in == acs_pkg::MODE_BACK;
            end else if (bg_on && filt_vld) begin
                bg_cnt_r <= (bg_cnt_r == 3'h5) ? 3'h0 : bg_cnt_r + 3'h1;
                if (bg_full) begin
                    bg_first_r <= 1'b0;
                end
            end
        end
    end
    // ready strobe: raised on a calibration command or a read, low on result or done
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_ready_n <= 1'b1;
            out_word     <= '0;
            out_invalid  <= 1'b0;
        end else begin
            if (cmd_go) begin
                data_ready_n <= 1'b1;
            end else if (state_r == acs_pkg::ACS_DONE) begin
                data_ready_n <= 1'b0;
            end else if (corr_vld) begin
                out_word     <= word_16 ? {corr_word[acs_pkg::OUT_W-1:8], 8'h00} : corr_word;
                out_invalid  <= bg_first_r;
                data_ready_n <= 1'b0;
            end else if (rd_edge) begin
                data_ready_n <= 1'b1;
            end
        end
    end
    cal_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_go |=> data_ready_n) else $error("ready not raised on command");
    flt_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_go |=> filter_reset) else $error("filter not reset");
    done_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == acs_pkg::ACS_DONE && !cmd_go) |=> !data_ready_n)
        else $error("no ready at end");
    sys0_slope_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_r == acs_pkg::MODE_SYS0 && !bg_on) |=> $stable(gain_r))
        else $error("slope changed on zero step");
    bg_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bg_on && !mode_wr) |=> bg_on) else $error("background dropped");
    bg_cnt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bg_cnt_r <= 3'h5) else $error("slot counter overrange");
    norm_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == acs_pkg::ACS_IDLE && !bg_on) |=> $stable(offset_r))
        else $error("coefficients moved in normal mode");
    corr_rdy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (corr_vld && !cmd_go && state_r != acs_pkg::ACS_DONE) |=> !data_ready_n)
        else $error("new word not flagged");
    self_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == acs_pkg::ACS_ZERO && mode_r == acs_pkg::MODE_SELF)
        |=> input_select == acs_pkg::SRC_SHORT) else $error("self-cal source wrong");
    self_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        mode_r == acs_pkg::MODE_SELF && state_r == acs_pkg::ACS_DONE);
    sys_c: cover property (@(posedge clk_sys) disable iff (!rst_n) sys_full_r);
    bg_c: cover property (@(posedge clk_sys) disable iff (!rst_n) bg_full);
endmodule

// file: acs_host_model.sv
// far-side model: filter word timing and calibration node levels
`timescale 1ns/1ps
module acs_host_model #(
    parameter int                          PERIOD     = 20,
    parameter logic [acs_pkg::RAW_W-1:0]   SHORT_CODE = 24'h00_0000
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      filter_reset,
    input  wire logic [1:0]                input_select,
    input  wire logic [acs_pkg::RAW_W-1:0] ain_level,
    output logic                           out_period,
    output logic                           filt_vld,
    output logic      [acs_pkg::RAW_W-1:0] filt_data
);
    int                          cnt_r;
    logic [acs_pkg::RAW_W-1:0]   last_r;
    wire                         wrap = (cnt_r == PERIOD - 1);
    wire  [acs_pkg::RAW_W-1:0]   node = (input_select == acs_pkg::SRC_SHORT) ? SHORT_CODE :
                                        (input_select == acs_pkg::SRC_REF) ? acs_pkg::FULL_CODE :
                                        ain_level;

    // filter restarts its word period on a reset pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 0;
        end else if (filter_reset || wrap) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= '0;
        end else if (filt_vld) begin
            last_r <= filt_data;
        end
    end

    assign filt_vld   = wrap && !filter_reset;
    assign out_period = filt_vld;
    // data only meaningful with valid, otherwise shows the inverse of the last valid word
    assign filt_data  = filt_vld ? node : ~last_r;
endmodule

// file: acs_seq_bench.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module acs_seq_bench;
    logic                          clk_sys;
    logic                          rst_n;
    logic                          b2;
    logic                          b1;
    logic                          b0;
    logic                          mode_wr;
    logic                          bipolar;
    logic [acs_pkg::GAIN_W-1:0]    pga_gain;
    logic                          word_16;
    logic                          last_bit_read;
    logic [acs_pkg::RAW_W-1:0]     ain_level;
    wire                           out_period;
    wire                           filt_vld;
    wire  [acs_pkg::RAW_W-1:0]     filt_data;
    wire                           filter_reset;
    wire  [1:0]                    input_select;
    wire  [acs_pkg::OUT_W-1:0]     out_word;
    wire                           out_invalid;
    wire                           data_ready_n;
    int                            n_errors;
    int                            n_compared;
    int                            n_cycles;
    int                            n_vld;
    int                            last_vld;
    logic [acs_pkg::OUT_W-1:0]     w;
    logic                          inv;
    int                            gap;

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    acs_seq u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cal_mode_bit2(b2), .cal_mode_bit1(b1),
        .cal_mode_bit0(b0), .mode_wr(mode_wr), .bipolar(bipolar), .pga_gain(pga_gain),
        .word_16(word_16), .out_period(out_period), .filt_vld(filt_vld),
        .filt_data(filt_data), .last_bit_read(last_bit_read), .filter_reset(filter_reset),
        .input_select(input_select), .out_word(out_word), .out_invalid(out_invalid),
        .data_ready_n(data_ready_n));

    acs_host_model #(.PERIOD(20)) u_host (.clk_sys(clk_sys), .rst_n(rst_n),
        .filter_reset(filter_reset), .input_select(input_select), .ain_level(ain_level),
        .out_period(out_period), .filt_vld(filt_vld), .filt_data(filt_data));

    // whole run needs well under two thousand cycles, ceiling at 30000 far above that
    always @(negedge clk_sys) begin
        n_cycles++;
        if (filt_vld === 1'b1) n_vld++;
        if (n_cycles == 30000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic release_read;
        int t;
        @(posedge clk_sys);
        last_bit_read <= 1'b1;
        t = 0;
        while (data_ready_n !== 1'b1 && t < 12) begin
            @(negedge clk_sys);
            t++;
        end
        check(data_ready_n, 1'b1, "ready after read");
        @(posedge clk_sys);
        last_bit_read <= 1'b0;
    endtask

    task automatic get_word(output logic [23:0] wd, output logic iv, output int gp);
        int t;
        t = 0;
        while (data_ready_n !== 1'b0 && t < 2000) begin
            @(negedge clk_sys);
            t++;
        end
        wd = out_word;
        iv = out_invalid;
        gp = n_vld - last_vld;
        last_vld = n_vld;
        release_read();
    endtask

    task automatic wr_mode(input logic [2:0] code);
        @(posedge clk_sys);
        {b2, b1, b0} <= code;
        mode_wr <= 1'b1;
        @(posedge clk_sys);
        mode_wr <= 1'b0;
    endtask

    // one calibration step, counting output periods until ready falls
    task automatic cal_step(input logic [2:0] code, input int per);
        int t;
        int np;
        int nv;
        wr_mode(code);
        @(negedge clk_sys);
        check(filter_reset, 1'b1, "filter reset");
        check(data_ready_n, 1'b1, "ready raised");
        np = 0;
        nv = 0;
        t = 0;
        // host looks at ready only after the command has been taken
        while (data_ready_n !== 1'b0 && t < 4000) begin
            if (filt_vld === 1'b1 && nv == 0) begin
                check(input_select, code == acs_pkg::MODE_SELF ? acs_pkg::SRC_SHORT :
                      acs_pkg::SRC_AIN, "first node");
            end
            if (filt_vld === 1'b1 && nv == 1 &&
                (code == acs_pkg::MODE_SELF || code == acs_pkg::MODE_SOFF)) begin
                check(input_select, acs_pkg::SRC_REF, "second node");
            end
            if (filt_vld === 1'b1) nv++;
            if (out_period === 1'b1) np++;
            @(negedge clk_sys);
            t++;
        end
        check(np, per, "periods to ready");
        check(data_ready_n, 1'b0, "ready at end");
        release_read();
        last_vld = n_vld;
    endtask

    initial begin
        n_errors = 0;
        n_compared = 0;
        n_cycles = 0;
        n_vld = 0;
        last_vld = 0;
        rst_n = 1'b0;
        {b2, b1, b0} = 3'h0;
        mode_wr = 1'b0;
        bipolar = 1'b0;
        pga_gain = 3'h0;
        word_16 = 1'b0;
        last_bit_read = 1'b0;
        ain_level = 24'h12_3456;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        get_word(w, inv, gap);
        check(w, 24'h12_3456, "word after reset");
        word_16 <= 1'b1;
        get_word(w, inv, gap);
        get_word(w, inv, gap);
        check(w, 24'h12_3400, "short word");
        word_16 <= 1'b0;
        ain_level <= 24'h00_1000;
        cal_step(acs_pkg::MODE_SYS0, 4);
        ain_level <= 24'h40_0000;
        get_word(w, inv, gap);
        check(w, 24'h3f_f000, "offset removed");
        wr_mode(3'h6);
        get_word(w, inv, gap);
        get_word(w, inv, gap);
        check(w, 24'h3f_f000, "coefficients kept");
        check(gap, 1, "normal word rate");
        cal_step(acs_pkg::MODE_SELF, 9);
        wr_mode(acs_pkg::MODE_BACK);
        get_word(w, inv, gap);
        check(inv, 1'b1, "first background word");
        get_word(w, inv, gap);
        check(inv, 1'b0, "later background word");
        check(gap, 6, "background rate");
        get_word(w, inv, gap);
        check(gap, 6, "background persists");
        wr_mode(acs_pkg::MODE_NORMAL);
        get_word(w, inv, gap);
        get_word(w, inv, gap);
        check(gap, 1, "rate back after exit");
        cal_step(acs_pkg::MODE_SOFF, 9);
        ain_level <= 24'h00_1000;
        cal_step(acs_pkg::MODE_SYS0, 4);
        ain_level <= 24'h80_1000;
        cal_step(acs_pkg::MODE_SYS1, 4);
        ain_level <= 24'h40_1000;
        get_word(w, inv, gap);
        check(w, 24'h7f_ffff, "system gain applied");
        ain_level <= 24'h00_2000;
        cal_step(acs_pkg::MODE_SYS0, 4);
        ain_level <= 24'h40_2000;
        get_word(w, inv, gap);
        check(w, 24'h7f_ffff, "slope kept after zero step");
        close_out();
    end
endmodule
